/* File: ebs_pkg.sv */
/*
  Shared constants and types for the expansion bus sequencer.
  Assumes one clock domain (hclk) and plain configuration ports.
*/
`default_nettype none

package ebs_pkg;

  // ****************************************
  // Widths, divisor limits, select codes and latch bits
  // ****************************************
  localparam int          HAW      = 28;
  localparam int          EAW      = 26;
  localparam int          NCS      = 5;
  localparam int          SEGW     = 8;
  localparam int          TW       = 4;
  localparam logic [3:0]  DIV_MIN  = 4'h3;
  localparam logic [3:0]  DIV_MAX  = 4'hf;
  localparam logic [2:0]  CS_MISS  = 3'h7;
  localparam logic [2:0]  CS_FLASH = 3'h4;
  localparam int          ALE_BIT  = 9;
  localparam int          CLE_BIT  = 10;

  // ****************************************
  // Access sizes
  // ****************************************
  localparam logic [1:0]  SZ_BYTE  = 2'h0;
  localparam logic [1:0]  SZ_HALF  = 2'h1;
  localparam logic [1:0]  SZ_WORD  = 2'h2;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_STRB = 6'h04,
    S_HOLD = 6'h08,
    S_DONE = 6'h10,
    S_ERR  = 6'h20
  } ebs_state_e;

endpackage

`default_nettype wire

/* File: ebs_clkdiv.sv */
/*
  Expansion clock divider: hclk divided by 3 to 15.
  Assumes the divisor is quasi-static while transfers run.
*/
`timescale 1ns/1ns
`default_nettype none

module ebs_clkdiv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Divisor
  input  wire logic [3:0] div,
  // Divided clock
  output logic            tick,
  output logic            lvl
);

  logic [3:0] n;
  logic [3:0] cnt_r;

  // ****************************************
  // Clamp divisor to the legal range
  // ****************************************
  always_comb begin
    n = div;
    if (div < ebs_pkg::DIV_MIN) n = ebs_pkg::DIV_MIN;
  end

  // ****************************************
  // Period counter
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
      lvl   <= 1'b0;
    end else if (ce) begin
      cnt_r <= (cnt_r >= n - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      tick  <= (cnt_r == n - 4'h1);
      lvl   <= (cnt_r < (n >> 1));
    end
  end

  a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    (tick && ce) |-> !$past(tick)) else $error("tick not a single pulse");

endmodule

`default_nettype wire

/* File: ebs_seq.sv */
/*
  AHB slave expansion bus sequencer for 8/16-bit peripherals.
  Assumes AHB on clk, configuration ports held static during transfers.
*/
// Summary of operation
// - Half-word drops address bit 0, word drops bits 1 and 0.
// - 8-bit bus: byte, half and word address with 0, 1 or 2 beat bits.
// - 16-bit bus: haddr[26:1] for byte/half, mask from bit 0, word adds beat bit.
// - Peripheral address is address bits above beat bits; beat steps per cycle.
// - Select 4 pin is flash write strobe while flash mode is set, generic select 4 otherwise.
// - Expansion clock leaves the pin only while clock-out enable is set.
// - Both mode selectors clear means normal mode.
// - Select and strobe assert a setup count after the address.
// - Expansion clock is clk divided by 3 to 15; counts use it.
// - Read releases the bus and captures data when strobe ends.
// - Select ends on width expiry or a seen ready deassertion.
// - Write data stays driven a hold count after select ends.
// - Next transaction waits for the hold count to expire.
// - Address outside every select window gets an error response.
// - Ready is synchronised to clk before ending a cycle.
// - Ready enabled but never seen gives an error response.
// - Outside strobe mode, reads pulse only the read strobe, writes only the write strobe.
// - Address-latch mode sends address then data with a high latch strobe.
// - Address held for the hold time before data; also on address lines.
// - Strobe mode: write pin is direction, read pin is command strobe.
// - Flash access uses its own select pin and normal-mode cycles.
// - Flash strobes also toggle on accesses to selects 0 to 3.
// - Flash latch enables follow address bits 9 and 10.
// - Words to narrow buses go out over several beats, AHB stalled.
// - Byte read data is replicated across all AHB byte lanes, half-word data across both halves.
`timescale 1ns/1ns
`default_nettype none

module ebs_seq (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // AHB slave
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [27:0] haddr,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Configuration
  input  wire logic [39:0] cs_base,
  input  wire logic [39:0] cs_seg,
  input  wire logic [4:0]  ale_mode_sel,
  input  wire logic [4:0]  strobe_mode_sel,
  input  wire logic [4:0]  rdy_en,
  input  wire logic [4:0]  bus16,
  input  wire logic        flash_mode,
  input  wire logic        select4_generic_enable,
  input  wire logic        clk_out_enable,
  input  wire logic [3:0]  clk_div,
  input  wire logic [3:0]  t_setup,
  input  wire logic [3:0]  t_width,
  input  wire logic [3:0]  t_hold,
  input  wire logic [3:0]  t_ahold,
  input  wire logic        rw_pol,
  input  wire logic        strb_pol,
  // Expansion pins
  output logic             exp_clk,
  output logic      [25:0] exp_addr,
  output logic      [15:0] exp_dout,
  output logic             exp_doe,
  input  wire logic [15:0] exp_din,
  input  wire logic        exp_rdy,
  output logic      [3:0]  cs_n,
  output logic             select4_pin_n,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             ale,
  output logic      [1:0]  write_byte_mask,
  output logic             flash_read_strobe_n,
  output logic             flash_select_pin_n,
  output logic             flash_ale,
  output logic             flash_cle
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [2:0] hit_f(input logic [7:0] a, input logic [39:0] b,
                                       input logic [39:0] s, input logic en4);
    logic [2:0] r;
    r = ebs_pkg::CS_MISS;
    for (int i = ebs_pkg::NCS - 1; i >= 0; i--) begin
      if ((i < 4 || en4) && (a - b[8*i +: 8]) < s[8*i +: 8]) r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic [1:0] last_f(input logic [1:0] sz, input logic b16);
    if (sz == ebs_pkg::SZ_WORD) return b16 ? 2'h1 : 2'h3;
    if (sz == ebs_pkg::SZ_HALF) return b16 ? 2'h0 : 2'h1;
    return 2'h0;
  endfunction

  function automatic logic [25:0] addr_f(input logic [27:0] a, input logic [1:0] sz,
                                         input logic b16, input logic [1:0] bt);
    if (b16) begin
      if (sz == ebs_pkg::SZ_WORD) return {a[26:2], bt[0]};
      return a[26:1];
    end
    if (sz == ebs_pkg::SZ_WORD) return {a[25:2], bt};
    if (sz == ebs_pkg::SZ_HALF) return {a[25:1], bt[0]};
    return a[25:0];
  endfunction

  // ****************************************
  // Request state
  // ****************************************
  ebs_pkg::ebs_state_e st_r;
  logic [27:0] a_r;
  logic [1:0]  sz_r;
  logic        wr_r;
  logic [2:0]  cs_r;
  logic        b16_r;
  logic        ale_r;
  logic        strb_r;
  logic        use_rdy_r;
  logic        flash_r;
  logic        wcap_r;
  logic [31:0] wdat_r;
  logic [31:0] rd_r;
  logic [1:0]  beat_r;
  logic [1:0]  last_r;
  logic [3:0]  cnt_r;
  logic        err_r;
  logic        seen_r;
  logic        rdy_s1;
  logic        rdy_s2;
  logic        rdy_s3;
  logic        rdy_fall;
  logic        tick;
  logic        lvl;
  logic        take;
  logic [2:0]  hit;
  logic        strb_end;
  logic [25:0] ea;
  logic [1:0]  lane;

  ebs_clkdiv u_div (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .div    (clk_div),
    .tick   (tick),
    .lvl    (lvl)
  );

  assign take     = hsel && htrans[1] && hready_in && hreadyout && st_r == ebs_pkg::S_IDLE;
  assign hit      = hit_f(haddr[27:20], cs_base, cs_seg, flash_mode | select4_generic_enable);
  assign rdy_fall = rdy_s3 && !rdy_s2;
  assign strb_end = (cnt_r == 4'h0) || (use_rdy_r && rdy_fall);
  assign ea       = addr_f(a_r, sz_r, b16_r, beat_r);

  // ****************************************
  // Ready synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
    end else if (ce) begin
      rdy_s1 <= exp_rdy;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= ebs_pkg::S_IDLE;
      cnt_r  <= 4'h0;
      beat_r <= 2'h0;
      err_r  <= 1'b0;
      seen_r <= 1'b0;
    end else if (ce) begin
      unique case (st_r)
        ebs_pkg::S_IDLE: begin
          err_r  <= 1'b0;
          beat_r <= 2'h0;
          if (take && hit == ebs_pkg::CS_MISS) begin
            err_r <= 1'b1;
            st_r  <= ebs_pkg::S_DONE;
          end else if (take) begin
            cnt_r <= t_setup;
            st_r  <= ebs_pkg::S_ADDR;
          end
        end
        ebs_pkg::S_ADDR: begin
          seen_r <= 1'b0;
          if (cnt_r == 4'h0) begin
            cnt_r <= t_width;
            st_r  <= ebs_pkg::S_STRB;
          end else if (tick) begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ebs_pkg::S_STRB: begin
          if (strb_end) begin
            if (use_rdy_r && !rdy_fall && !seen_r) err_r <= 1'b1;
            cnt_r <= t_hold;
            st_r  <= ebs_pkg::S_HOLD;
          end else if (tick) begin
            cnt_r <= cnt_r - 4'h1;
          end
          if (rdy_fall) seen_r <= 1'b1;
        end
        ebs_pkg::S_HOLD: begin
          if (cnt_r == 4'h0) begin
            if (beat_r == last_r) begin
              st_r <= ebs_pkg::S_DONE;
            end else begin
              beat_r <= beat_r + 2'h1;
              cnt_r  <= t_setup;
              st_r   <= ebs_pkg::S_ADDR;
            end
          end else if (tick) begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ebs_pkg::S_DONE: begin
          st_r <= err_r ? ebs_pkg::S_ERR : ebs_pkg::S_IDLE;
        end
        ebs_pkg::S_ERR: begin
          st_r <= ebs_pkg::S_IDLE;
        end
        default: begin
          st_r <= ebs_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Request capture
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_r       <= 28'h0;
      sz_r      <= 2'h0;
      wr_r      <= 1'b0;
      cs_r      <= 3'h0;
      b16_r     <= 1'b0;
      ale_r     <= 1'b0;
      strb_r    <= 1'b0;
      use_rdy_r <= 1'b0;
      flash_r   <= 1'b0;
      last_r    <= 2'h0;
      wcap_r    <= 1'b0;
      wdat_r    <= 32'h0;
    end else if (ce) begin
      wcap_r <= take && hwrite;
      if (wcap_r) wdat_r <= hwdata;
      if (take && hit != ebs_pkg::CS_MISS) begin
        a_r       <= haddr;
        sz_r      <= (hsize[1:0] > ebs_pkg::SZ_WORD) ? ebs_pkg::SZ_WORD : hsize[1:0];
        wr_r      <= hwrite;
        cs_r      <= hit;
        flash_r   <= flash_mode && hit == ebs_pkg::CS_FLASH;
        b16_r     <= bus16[hit];
        last_r    <= last_f((hsize[1:0] > ebs_pkg::SZ_WORD) ? ebs_pkg::SZ_WORD : hsize[1:0], bus16[hit]);
        use_rdy_r <= rdy_en[hit];
        // Flash cycles always run as normal mode
        ale_r     <= ale_mode_sel[hit] && !strobe_mode_sel[hit] &&
                     !(flash_mode && hit == ebs_pkg::CS_FLASH);
        strb_r    <= strobe_mode_sel[hit] && !ale_mode_sel[hit] &&
                     !(flash_mode && hit == ebs_pkg::CS_FLASH);
      end
    end
  end

  // ****************************************
  // Read assembly and AHB response
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_r      <= 32'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      if (st_r == ebs_pkg::S_STRB && strb_end && !wr_r) begin
        if (b16_r) rd_r[16*beat_r[0] +: 16] <= exp_din;
        else rd_r[8*beat_r +: 8] <= exp_din[7:0];
      end
      if (take) hreadyout <= 1'b0;
      if (st_r == ebs_pkg::S_IDLE) hresp <= 1'b0;
      if (st_r == ebs_pkg::S_DONE) begin
        hresp     <= err_r;
        hreadyout <= !err_r;
        if (sz_r == ebs_pkg::SZ_WORD) hrdata <= rd_r;
        else if (sz_r == ebs_pkg::SZ_HALF) hrdata <= {2{rd_r[15:0]}};
        else if (b16_r && a_r[0]) hrdata <= {4{rd_r[15:8]}};
        else hrdata <= {4{rd_r[7:0]}};
      end
      if (st_r == ebs_pkg::S_ERR) hreadyout <= 1'b1;
    end
  end

  // ****************************************
  // Expansion pins
  // ****************************************
  always_comb begin
    lane = beat_r;
    if (b16_r) lane = (sz_r == ebs_pkg::SZ_WORD) ? {1'b0, beat_r[0]} : {1'b0, a_r[1]};
    else if (sz_r == ebs_pkg::SZ_BYTE) lane = a_r[1:0];
    else if (sz_r == ebs_pkg::SZ_HALF) lane = {a_r[1], beat_r[0]};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_clk             <= 1'b0;
      exp_addr            <= 26'h0;
      exp_dout            <= 16'h0;
      exp_doe             <= 1'b0;
      cs_n                <= 4'hf;
      select4_pin_n       <= 1'b1;
      write_strobe_n      <= 1'b1;
      read_strobe_n       <= 1'b1;
      ale                 <= 1'b0;
      write_byte_mask     <= 2'h0;
      flash_read_strobe_n <= 1'b1;
      flash_select_pin_n  <= 1'b1;
      flash_ale           <= 1'b0;
      flash_cle           <= 1'b0;
    end else if (ce) begin
      exp_clk  <= clk_out_enable && lvl;
      exp_addr <= ea;
      flash_ale <= flash_r && ea[ebs_pkg::ALE_BIT];
      flash_cle <= flash_r && ea[ebs_pkg::CLE_BIT];
      flash_select_pin_n <= !(flash_r && (st_r == ebs_pkg::S_ADDR ||
                              st_r == ebs_pkg::S_STRB || st_r == ebs_pkg::S_HOLD));
      // Address latch phase ends t_ahold ticks before the strobe
      ale <= ale_r && st_r == ebs_pkg::S_ADDR && cnt_r > t_ahold;
      if (ale_r && st_r == ebs_pkg::S_ADDR) begin
        exp_dout <= ea[15:0];
        exp_doe  <= 1'b1;
      end else begin
        exp_dout <= b16_r ? wdat_r[16*lane[0] +: 16] : {8'h0, wdat_r[8*lane +: 8]};
        exp_doe  <= wr_r && (st_r == ebs_pkg::S_STRB || st_r == ebs_pkg::S_HOLD ||
                    st_r == ebs_pkg::S_ADDR);
      end
      write_byte_mask <= (b16_r && sz_r == ebs_pkg::SZ_BYTE) ?
                         (a_r[0] ? 2'h1 : 2'h2) : 2'h0;
      cs_n <= 4'hf;
      if (st_r == ebs_pkg::S_STRB && !strb_end && cs_r < 3'h4) cs_n[cs_r[1:0]] <= 1'b0;
      if (flash_mode)
        select4_pin_n <= !(st_r == ebs_pkg::S_STRB && !strb_end && wr_r);
      else
        select4_pin_n <= !(st_r == ebs_pkg::S_STRB && !strb_end && cs_r == 3'h4);
      flash_read_strobe_n <= !(flash_mode && st_r == ebs_pkg::S_STRB && !strb_end && !wr_r);
      if (strb_r) begin
        write_strobe_n <= rw_pol ? !wr_r : wr_r;
        read_strobe_n  <= strb_pol ? (st_r == ebs_pkg::S_STRB && !strb_end)
                                   : !(st_r == ebs_pkg::S_STRB && !strb_end);
      end else begin
        write_strobe_n <= !(st_r == ebs_pkg::S_STRB && !strb_end && wr_r && !flash_r);
        read_strobe_n  <= !(st_r == ebs_pkg::S_STRB && !strb_end && !wr_r && !flash_r);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_setup_wait: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ebs_pkg::S_ADDR && cnt_r != 4'h0) |=> st_r == ebs_pkg::S_ADDR)
    else $error("strobe before setup count");

  a_hold_wait: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ebs_pkg::S_HOLD && cnt_r != 4'h0) |=> st_r == ebs_pkg::S_HOLD)
    else $error("next cycle before hold count");

  a_rdy_end: assert property (@(posedge clk) disable iff (!resetn)
    (ce && st_r == ebs_pkg::S_STRB && use_rdy_r && rdy_fall) |=> st_r == ebs_pkg::S_HOLD)
    else $error("ready fall did not end select");

  a_rdy_error: assert property (@(posedge clk) disable iff (!resetn)
    (ce && st_r == ebs_pkg::S_STRB && cnt_r == 4'h0 && use_rdy_r && !rdy_fall && !seen_r)
    |=> err_r) else $error("missing ready not flagged");

  a_err_resp: assert property (@(posedge clk) disable iff (!resetn)
    (ce && st_r == ebs_pkg::S_ERR) |=> hresp && hreadyout && $past(hresp) && !$past(hreadyout))
    else $error("bad error response");

  a_busy_wait: assert property (@(posedge clk) disable iff (!resetn)
    (st_r != ebs_pkg::S_IDLE && st_r != ebs_pkg::S_ERR) |-> !hreadyout)
    else $error("ready during transfer");

  a_one_strobe: assert property (@(posedge clk) disable iff (!resetn)
    !strb_r |-> !(!write_strobe_n && !read_strobe_n))
    else $error("both strobes active");

  a_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == ebs_pkg::S_STRB && $past(st_r) == ebs_pkg::S_STRB) |-> $stable(exp_addr))
    else $error("address moved during strobe");

  a_clk_off: assert property (@(posedge clk) disable iff (!resetn)
    ($past(ce) && !$past(clk_out_enable)) |-> !exp_clk)
    else $error("clock out while disabled");

  a_read_repl: assert property (@(posedge clk) disable iff (!resetn)
    ($rose(hreadyout) && !hresp && !wr_r && sz_r == ebs_pkg::SZ_BYTE)
    |-> hrdata[31:24] == hrdata[7:0]) else $error("byte not replicated");

endmodule

`default_nettype wire

/* File: ebs_periph.sv */
/*
  Behavioural 8-bit peripheral model for the expansion bus sequencer bench.
  Assumes active-low select and strobes, registered pins, one clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ebs_periph (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Pins from the sequencer
  input  wire logic        sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  din,
  // Ready behaviour
  input  wire logic        rdy_on,
  // Pins to the sequencer
  output logic      [15:0] dout,
  output logic             rdy
);
  // ****************************************
  // Storage and pin state
  // ****************************************
  logic [7:0]  mem [256];
  logic [15:0] last_r;
  logic        wr_q;
  logic        act_q;

  // Write data taken on the strobe's rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b1;
    end else begin
      wr_q <= wr_n;
      if (wr_n && !wr_q) begin
        mem[addr] <= din;
      end
    end
  end

  // Bus shows inverse of last value when not read
  always_comb begin
    dout = rd_n ? ~last_r : {~mem[addr], mem[addr]};
  end

  // Ready dropped one cycle into a selected access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_r <= 16'h0000;
      act_q  <= 1'b0;
      rdy    <= 1'b1;
    end else begin
      last_r <= dout;
      act_q  <= !sel_n;
      rdy    <= !(rdy_on && act_q && !sel_n);
    end
  end
endmodule

`default_nettype wire

/* File: expansion_bus_access_sequencer_tb_top.sv */
/*
  Self-checking bench for the expansion bus sequencer.
  Assumes ebs_pkg, ebs_seq and ebs_periph are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module expansion_bus_access_sequencer_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, resetn, ce, hsel, hwrite, hready_in, hreadyout, hresp;
  logic        flash_mode, select4_generic_enable, clk_out_enable, rw_pol, strb_pol;
  logic        exp_clk, exp_doe, exp_rdy, select4_pin_n, write_strobe_n, read_strobe_n;
  logic        ale, flash_read_strobe_n, flash_select_pin_n, flash_ale, flash_cle, rdy_on;
  logic [1:0]  htrans, write_byte_mask, msk;
  logic [2:0]  hsize;
  logic [27:0] haddr;
  logic [31:0] hwdata, hrdata, rdat;
  logic [39:0] cs_base, cs_seg;
  logic [4:0]  ale_mode_sel, strobe_mode_sel, rdy_en, bus16;
  logic [3:0]  clk_div, t_setup, t_width, t_hold, t_ahold, cs_n;
  logic [25:0] exp_addr, ea;
  logic [15:0] exp_dout, exp_din;
  logic        err, rd, wr, fa, fc, fs, s4, frs, doe, al;
  int          n_fail, tests_run;

  ebs_seq i_dut (.clk, .resetn, .ce, .hsel, .htrans, .hwrite, .hsize, .haddr, .hwdata, .hready_in,
    .hrdata, .hreadyout, .hresp, .cs_base, .cs_seg, .ale_mode_sel, .strobe_mode_sel, .rdy_en, .bus16,
    .flash_mode, .select4_generic_enable, .clk_out_enable, .clk_div, .t_setup, .t_width, .t_hold,
    .t_ahold, .rw_pol, .strb_pol, .exp_clk, .exp_addr, .exp_dout, .exp_doe, .exp_din, .exp_rdy, .cs_n,
    .select4_pin_n, .write_strobe_n, .read_strobe_n, .ale, .write_byte_mask, .flash_read_strobe_n,
    .flash_select_pin_n, .flash_ale, .flash_cle);

  ebs_periph i_mem (.clk, .resetn, .sel_n(cs_n[0]), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
    .addr(exp_addr[7:0]), .din(exp_dout[7:0]), .rdy_on, .dout(exp_din), .rdy(exp_rdy));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One AHB transfer, pins watched until it completes
  task automatic ahb(input logic w, input logic [2:0] sz, input logic [27:0] a, input logic [31:0] d);
    int k;
    @(negedge clk);
    hsel = 1'b1;
    htrans = 2'h2;
    hwrite = w;
    hsize = sz;
    haddr = a;
    hwdata = d;
    @(negedge clk);
    hsel = 1'b0;
    htrans = 2'h0;
    {err, rd, wr, fa, fc, fs, s4, frs, doe, al} = '0;
    for (k = 0; k < 600; k++) begin
      @(negedge clk);
      err |= hresp;
      rd |= !read_strobe_n;
      wr |= !write_strobe_n;
      fa |= flash_ale;
      fc |= flash_cle;
      fs |= !flash_select_pin_n;
      s4 |= !select4_pin_n;
      frs |= !flash_read_strobe_n;
      doe |= exp_doe;
      al |= ale;
      if (!write_strobe_n || !read_strobe_n || !select4_pin_n) begin
        msk = write_byte_mask;
        ea = exp_addr;
      end
      if (hreadyout === 1'b1) break;
    end
    rdat = hrdata;
    if (k == 600) chk(1'b0, "transfer never completed");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_cs0();
    ahb(1'b1, ebs_pkg::SZ_WORD, 28'h0000040, 32'ha1b2c3d4);
    chk(!err && wr && !rd, "word write strobes");
    chk(i_mem.mem[8'h40] === 8'hd4 && i_mem.mem[8'h43] === 8'ha1, "word beats");
    chk(ea[7:0] === 8'h43, "last beat address");
    ahb(1'b0, ebs_pkg::SZ_WORD, 28'h0000042, 32'h0);
    chk(rdat === 32'ha1b2c3d4 && rd && !wr && !doe, "word read");
    chk(frs, "flash read strobe on select 0");
    ahb(1'b1, ebs_pkg::SZ_HALF, 28'h0000011, 32'hbeefbeef);
    chk(i_mem.mem[8'h10] === 8'hef && i_mem.mem[8'h11] === 8'hbe, "half beats");
    ahb(1'b0, ebs_pkg::SZ_BYTE, 28'h0000041, 32'h0);
    chk(rdat === {4{8'hc3}}, "byte replicated");
  endtask

  task automatic t_err();
    ahb(1'b0, ebs_pkg::SZ_BYTE, 28'h0800000, 32'h0);
    chk(err && !rd, "miss response");
    @(negedge clk);
    rdy_en = 5'h01;
    rdy_on = 1'b1;
    t_width = 4'hf;
    ahb(1'b0, ebs_pkg::SZ_BYTE, 28'h0000041, 32'h0);
    chk(!err && rdat === {4{8'hc3}}, "ready ended read");
    rdy_on = 1'b0;
    ahb(1'b0, ebs_pkg::SZ_BYTE, 28'h0000041, 32'h0);
    chk(err, "missing ready");
    rdy_en = 5'h00;
    t_width = 4'h2;
  endtask

  task automatic t_modes();
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h0200011, 32'h0);
    chk(msk === 2'h1 && ea === 26'h0100008, "16-bit byte write");
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h1000200, 32'h00000055);
    chk(fa && !fc && fs && s4 && !rd, "flash address latch");
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h1000400, 32'h00000070);
    chk(fc && !fa && fs, "flash command latch");
    @(negedge clk);
    flash_mode = 1'b0;
    select4_generic_enable = 1'b1;
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h1000000, 32'h0);
    chk(s4 && !fs, "generic select 4");
    ale_mode_sel = 5'h01;
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h0000020, 32'h0000005a);
    chk(al && !err, "address latch mode");
    ale_mode_sel = 5'h00;
    strobe_mode_sel = 5'h01;
    ahb(1'b1, ebs_pkg::SZ_BYTE, 28'h0000020, 32'h0);
    chk(rd && !wr && !err, "strobe mode write");
    strobe_mode_sel = 5'h00;
  endtask

  task automatic t_clk();
    logic [3:0] dv [3] = '{4'h3, 4'h5, 4'hf};
    int i, n, c;
    for (i = 0; i < 3; i++) begin
      clk_div = dv[i];
      repeat (40) @(negedge clk);
      n = 0;
      for (c = 0; c < 30; c++) begin
        @(negedge clk);
        n += exp_clk;
      end
      chk(n == 30 / dv[i] * (dv[i] / 2), "divided clock duty");
    end
    clk_out_enable = 1'b0;
    n = 0;
    repeat (3) @(negedge clk);
    repeat (30) @(negedge clk) n += exp_clk;
    chk(n == 0, "clock suppressed");
    clk_out_enable = 1'b1;
    clk_div = 4'h3;
  endtask

  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {resetn, hsel, hwrite, rw_pol, strb_pol, rdy_on, select4_generic_enable} = '0;
    {htrans, hsize, haddr, hwdata, ale_mode_sel, strobe_mode_sel, rdy_en} = '0;
    {ce, hready_in, flash_mode, clk_out_enable} = 4'hf;
    cs_base = {8'h10, 8'h00, 8'h00, 8'h02, 8'h00};
    cs_seg = {8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    bus16 = 5'h02;
    {clk_div, t_setup, t_width, t_hold, t_ahold} = {4'h3, 4'h1, 4'h2, 4'h1, 4'h0};
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    chk(hreadyout === 1'b1 && hresp === 1'b0 && cs_n === 4'hf, "reset state");
    t_cs0();
    t_err();
    t_modes();
    t_clk();
    close_out();
  end

  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
endmodule

`default_nettype wire
